// *** hw/rscu_pkg.sv ***
// Constants and types for the radio strobe command unit
// Overview of operation
// - Oscillator-off strobe switches the crystal oscillator off
// - Oscillator-off while radio not idle raises misuse
// - Oscillator-off or receive-flush during frame raises abort
// - Receive-flush empties receive FIFO, resets demodulator
// - Ack-send queues ack, pending bit zero
// - Ack-pending queues ack, pending bit one
// - Ack strobes without frame: misuse, no ack
// - Ack-suppress cancels a queued ack for current frame; a later ack strobe re-arms it
// - Mask-bit-set sets mask bit 13 only
// - Mask-bit-clear clears mask bit 13 only
// - Mask cleared to zero raises receive-enable-empty
// - Mask-OR ORs 16-bit host operand into mask
package rscu_pkg;

  // ---------------------------------------------------------------
  // Instruction opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_OSC_OFF = 8'h30;
  localparam logic [7:0] OP_RX_FLUSH = 8'h31;
  localparam logic [7:0] OP_TX_FLUSH = 8'h32;
  localparam logic [7:0] OP_ACK_SEND = 8'h33;
  localparam logic [7:0] OP_ACK_PEND = 8'h34;
  localparam logic [7:0] OP_ACK_SUPP = 8'h35;
  localparam logic [7:0] OP_MASK_SET = 8'h36;
  localparam logic [7:0] OP_MASK_CLR = 8'h37;
  localparam logic [7:0] OP_MASK_OR = 8'h38;

  // ---------------------------------------------------------------
  // Receive-enable mask
  // ---------------------------------------------------------------
  localparam int MASK_BIT = 13;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] MASK_KEEP = 16'hDFFF;

  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam logic [3:0] ADR_EVT = 4'h0;
  localparam logic [3:0] ADR_EVT_EN = 4'h4;
  localparam logic [3:0] ADR_MASK = 4'h8;
  localparam logic [3:0] ADR_CTRL = 4'hC;
  localparam int EV_MISUSE = 0;
  localparam int EV_ABORT = 1;
  localparam int EV_EMPTY = 2;
  localparam int EV_ACK_TX = 3;
  localparam int CTRL_OSC = 0;
  localparam logic [3:0] EVT_RST = 4'h0;
  localparam logic OSC_RST = 1'b1;
  localparam logic [2:0] PIN_RST = 3'h4;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OP = 2'b01,
    ST_D1 = 2'b11,
    ST_D2 = 2'b10
  } rscu_state_t;

endpackage

// *** hw/rscu_top.sv ***
// Strobe command unit: SPI instruction decoder, ack control, mask, events
`timescale 1ns/1ps
`default_nettype none
module rscu_top
  import rscu_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  input wire logic rf_idle,
  input wire logic rx_frame_active,
  input wire logic rx_frame_done,
  output logic osc_enable,
  output logic rx_fifo_flush,
  output logic demod_reset,
  output logic tx_fifo_flush,
  output logic ack_tx_start,
  output logic ack_frame_pending,
  output logic ack_suppress,
  output logic [15:0] receive_enable_mask,
  output logic irq,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  function automatic logic is_ack(input logic [7:0] op);
    is_ack = (op == OP_ACK_SEND) || (op == OP_ACK_PEND) || (op == OP_ACK_SUPP);
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] pin_f;
  assign pin_raw = {spi_cs_n, spi_mosi, spi_sclk};

  for (genvar gi = 0; gi < 3; gi++) begin : g_sync
    logic [2:0] sh_reg;
    logic filt_reg;
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        sh_reg <= {3{PIN_RST[gi]}};
        filt_reg <= PIN_RST[gi];
      end else begin
        sh_reg <= {sh_reg[1:0], pin_raw[gi]};
        if (sh_reg[1] == sh_reg[2]) begin
          filt_reg <= sh_reg[2];
        end
      end
    end
    assign pin_f[gi] = filt_reg;
  end

  logic sclk_d_reg;
  logic cs_d_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= pin_f[0];
      cs_d_reg <= pin_f[2];
    end
  end
  assign sclk_rise = pin_f[0] && !sclk_d_reg && !pin_f[2];
  assign sclk_fall = !pin_f[0] && sclk_d_reg && !pin_f[2];
  assign cs_fall = !pin_f[2] && cs_d_reg;

  // ---------------------------------------------------------------
  // Instruction receiver
  // ---------------------------------------------------------------
  rscu_state_t state_reg;
  logic [2:0] bit_reg;
  logic [7:0] rx_sh_reg;
  logic [7:0] hi_reg;
  logic [7:0] op_reg;
  logic [15:0] data_reg;
  logic exec_reg;
  logic [7:0] rx_byte;
  logic byte_done;
  assign rx_byte = {rx_sh_reg[6:0], pin_f[1]};
  assign byte_done = sclk_rise && (bit_reg == BIT_LAST);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      bit_reg <= 3'h0;
      rx_sh_reg <= 8'h00;
      hi_reg <= 8'h00;
      op_reg <= 8'h00;
      data_reg <= 16'h0000;
      exec_reg <= 1'b0;
    end else begin
      exec_reg <= 1'b0;
      if (pin_f[2]) begin
        state_reg <= ST_IDLE;
        bit_reg <= 3'h0;
      end else if (cs_fall) begin
        state_reg <= ST_OP;
        bit_reg <= 3'h0;
      end else if (sclk_rise) begin
        rx_sh_reg <= rx_byte;
        bit_reg <= bit_reg + 3'h1;
        if (byte_done) begin
          unique case (state_reg)
            ST_IDLE: state_reg <= ST_IDLE;
            ST_OP: begin
              op_reg <= rx_byte;
              if (rx_byte == OP_MASK_OR) begin
                state_reg <= ST_D1;
              end else begin
                exec_reg <= 1'b1;
              end
            end
            ST_D1: begin
              hi_reg <= rx_byte;
              state_reg <= ST_D2;
            end
            ST_D2: begin
              data_reg <= {hi_reg, rx_byte};
              exec_reg <= 1'b1;
              state_reg <= ST_OP;
            end
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Status byte shifter
  // ---------------------------------------------------------------
  logic osc_reg;
  logic ack_arm_reg;
  logic ack_fp_reg;
  logic supp_reg;
  logic [15:0] mask_reg;
  logic [3:0] evt_reg;
  logic [3:0] evt_en_reg;
  logic [7:0] status_byte;
  logic [7:0] tx_sh_reg;
  logic skip_reg;
  logic miso_reg;
  logic oe_n_reg;
  assign status_byte = {osc_reg, rf_idle, rx_frame_active, evt_reg[EV_MISUSE],
                        evt_reg[EV_ABORT], evt_reg[EV_EMPTY], ack_arm_reg, |mask_reg};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_sh_reg <= 8'h00;
      skip_reg <= 1'b0;
      miso_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      oe_n_reg <= pin_f[2];
      if (cs_fall || (byte_done && (state_reg == ST_OP) && (rx_byte != OP_MASK_OR))
          || (byte_done && (state_reg == ST_D2))) begin
        tx_sh_reg <= status_byte;
        miso_reg <= status_byte[7];
        skip_reg <= !cs_fall;
      end else if (sclk_fall) begin
        if (skip_reg) begin
          skip_reg <= 1'b0;
        end else begin
          tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
          miso_reg <= tx_sh_reg[6];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Strobe execution
  // ---------------------------------------------------------------
  logic bus_take;
  logic [3:0] evt_set;
  logic [3:0] evt_clr;
  logic osc_on_wr;
  logic x_osc;
  logic x_rxf;
  logic x_clr;
  logic rx_flush_reg;
  logic tx_flush_reg;
  logic ack_tx_reg;
  logic ack_fp_out_reg;

  assign x_osc = exec_reg && (op_reg == OP_OSC_OFF);
  assign x_rxf = exec_reg && (op_reg == OP_RX_FLUSH);
  assign x_clr = exec_reg && (op_reg == OP_MASK_CLR);
  assign osc_on_wr = bus_take && avs_write && (avs_address == ADR_CTRL)
                     && avs_writedata[CTRL_OSC];

  always_comb begin
    evt_set = 4'h0;
    evt_set[EV_MISUSE] = (x_osc && !rf_idle)
                         || (exec_reg && is_ack(op_reg) && !rx_frame_active);
    evt_set[EV_ABORT] = (x_osc || x_rxf) && rx_frame_active;
    evt_set[EV_EMPTY] = x_clr && ((mask_reg & MASK_KEEP) == 16'h0000);
    evt_set[EV_ACK_TX] = rx_frame_done && ack_arm_reg;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      osc_reg <= OSC_RST;
    end else if (x_osc) begin
      osc_reg <= 1'b0;
    end else if (osc_on_wr) begin
      osc_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_flush_reg <= 1'b0;
      tx_flush_reg <= 1'b0;
    end else begin
      rx_flush_reg <= x_rxf;
      tx_flush_reg <= exec_reg && (op_reg == OP_TX_FLUSH);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ack_arm_reg <= 1'b0;
      ack_fp_reg <= 1'b0;
      supp_reg <= 1'b0;
      ack_tx_reg <= 1'b0;
      ack_fp_out_reg <= 1'b0;
    end else begin
      ack_tx_reg <= rx_frame_done && ack_arm_reg;
      if (rx_frame_done) begin
        ack_fp_out_reg <= ack_fp_reg;
      end
      if (rx_frame_done || !rx_frame_active) begin
        ack_arm_reg <= 1'b0;
        supp_reg <= 1'b0;
      end else if (exec_reg && (op_reg == OP_ACK_SEND)) begin
        ack_arm_reg <= 1'b1;
        ack_fp_reg <= 1'b0;
        supp_reg <= 1'b0;
      end else if (exec_reg && (op_reg == OP_ACK_PEND)) begin
        ack_arm_reg <= 1'b1;
        ack_fp_reg <= 1'b1;
        supp_reg <= 1'b0;
      end else if (exec_reg && (op_reg == OP_ACK_SUPP)) begin
        ack_arm_reg <= 1'b0;
        supp_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mask_reg <= MASK_RST;
    end else if (exec_reg && (op_reg == OP_MASK_SET)) begin
      mask_reg[MASK_BIT] <= 1'b1;
    end else if (x_clr) begin
      mask_reg[MASK_BIT] <= 1'b0;
    end else if (exec_reg && (op_reg == OP_MASK_OR)) begin
      mask_reg <= mask_reg | data_reg;
    end
  end

  // ---------------------------------------------------------------
  // Avalon-MM slave and events
  // ---------------------------------------------------------------
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic irq_reg;
  assign bus_take = (avs_read || avs_write) && !wait_reg;
  assign evt_clr = (bus_take && avs_write && (avs_address == ADR_EVT))
                   ? avs_writedata[3:0] : 4'h0;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= !((avs_read || avs_write) && wait_reg);
      if (avs_read && wait_reg) begin
        unique case (avs_address)
          ADR_EVT: rdata_reg <= {28'h0, evt_reg};
          ADR_EVT_EN: rdata_reg <= {28'h0, evt_en_reg};
          ADR_MASK: rdata_reg <= {16'h0, mask_reg};
          ADR_CTRL: rdata_reg <= {29'h0, rx_frame_active, rf_idle, osc_reg};
          default: rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      evt_reg <= EVT_RST;
      evt_en_reg <= EVT_RST;
      irq_reg <= 1'b0;
    end else begin
      evt_reg <= (evt_reg & ~evt_clr) | evt_set;
      if (bus_take && avs_write && (avs_address == ADR_EVT_EN)) begin
        evt_en_reg <= avs_writedata[3:0];
      end
      irq_reg <= |(((evt_reg & ~evt_clr) | evt_set) & evt_en_reg);
    end
  end

  assign spi_miso = miso_reg;
  assign spi_miso_oe_n = oe_n_reg;
  assign osc_enable = osc_reg;
  assign rx_fifo_flush = rx_flush_reg;
  assign demod_reset = rx_flush_reg;
  assign tx_fifo_flush = tx_flush_reg;
  assign ack_tx_start = ack_tx_reg;
  assign ack_frame_pending = ack_fp_out_reg;
  assign ack_suppress = supp_reg;
  assign receive_enable_mask = mask_reg;
  assign irq = irq_reg;
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_osc_off;
    x_osc |=> !osc_enable ##1 (!osc_enable || $past(osc_on_wr));
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("osc not off");

  property p_misuse_osc;
    x_osc && !rf_idle |=> evt_reg[EV_MISUSE];
  endproperty
  a_misuse_osc: assert property (p_misuse_osc) else $error("no misuse");

  property p_abort;
    (x_osc || x_rxf) && rx_frame_active |=> evt_reg[EV_ABORT];
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");

  property p_rx_flush;
    x_rxf |=> rx_fifo_flush && demod_reset ##1 !rx_fifo_flush;
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("rx flush");

  property p_tx_flush;
    exec_reg && (op_reg == OP_TX_FLUSH) |-> (evt_set & 4'h7) == 4'h0 ##1 tx_fifo_flush;
  endproperty
  a_tx_flush: assert property (p_tx_flush) else $error("tx flush");

  property p_ack_out;
    rx_frame_done && ack_arm_reg |=> ack_tx_start && (ack_frame_pending == $past(ack_fp_reg));
  endproperty
  a_ack_out: assert property (p_ack_out) else $error("ack frame");

  property p_ack_pend;
    exec_reg && (op_reg == OP_ACK_PEND) && rx_frame_active && !rx_frame_done
      |=> ack_arm_reg && ack_fp_reg;
  endproperty
  a_ack_pend: assert property (p_ack_pend) else $error("ack pend");

  property p_ack_misuse;
    exec_reg && is_ack(op_reg) && !rx_frame_active |=> evt_reg[EV_MISUSE] && !ack_arm_reg;
  endproperty
  a_ack_misuse: assert property (p_ack_misuse) else $error("ack misuse");

  property p_nack;
    exec_reg && (op_reg == OP_ACK_SUPP) && rx_frame_active && !rx_frame_done
      |=> ack_suppress && !ack_arm_reg ##1 !ack_tx_start;
  endproperty
  a_nack: assert property (p_nack) else $error("nack");

  property p_mask_set;
    exec_reg && (op_reg == OP_MASK_SET)
      |=> mask_reg[MASK_BIT] && ((mask_reg & MASK_KEEP) == ($past(mask_reg) & MASK_KEEP));
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask set");

  property p_mask_clr;
    x_clr |=> !mask_reg[MASK_BIT] && ((mask_reg & MASK_KEEP) == ($past(mask_reg) & MASK_KEEP));
  endproperty
  a_mask_clr: assert property (p_mask_clr) else $error("mask clr");

  property p_empty;
    x_clr && ((mask_reg & MASK_KEEP) == 16'h0000) |=> evt_reg[EV_EMPTY];
  endproperty
  a_empty: assert property (p_empty) else $error("no empty");

  property p_mask_or;
    exec_reg && (op_reg == OP_MASK_OR) |=> mask_reg == ($past(mask_reg) | $past(data_reg));
  endproperty
  a_mask_or: assert property (p_mask_or) else $error("mask or");

  property p_status;
    cs_fall |=> (spi_miso == $past(status_byte[7])) && !spi_miso_oe_n;
  endproperty
  a_status: assert property (p_status) else $error("status byte");

endmodule
`default_nettype wire

// *** testbench/rscu_host.sv ***
// SPI host model that issues instruction bytes to the strobe unit
`timescale 1ns/1ps
`default_nettype none
module rscu_host (
  input wire logic clock,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe_n
);
  initial begin
    spi_sclk = 1'h0;
    spi_cs_n = 1'h1;
    spi_mosi = 1'h0;
  end

  // ---------------------------------------------------------------
  // Frame control
  // ---------------------------------------------------------------
  // Select, then leave the synchronisers time before the first edge
  task automatic sel();
    spi_cs_n <= 1'h0;
    repeat (8) @(posedge clock);
  endtask

  // Deselect; mosi parks at the inverse of its last bit
  task automatic desel();
    repeat (8) @(posedge clock);
    spi_cs_n <= 1'h1;
    spi_mosi <= ~spi_mosi;
    repeat (8) @(posedge clock);
  endtask

  // ---------------------------------------------------------------
  // Byte transfer
  // ---------------------------------------------------------------
  // MSB first, 200 ns per bit; miso taken late in the high phase
  task automatic xfer(input logic [7:0] b, output logic [7:0] s);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi <= b[i];
      repeat (4) @(posedge clock);
      spi_sclk <= 1'h1;
      repeat (4) @(posedge clock);
      s[i] = spi_miso_oe_n ? 1'hx : spi_miso;
      spi_sclk <= 1'h0;
    end
  endtask
endmodule
`default_nettype wire

// *** testbench/rscu_top_bench.sv ***
// Self-checking bench for the radio strobe command unit
`timescale 1ns/1ps
`default_nettype none
module rscu_top_bench;
  import rscu_pkg::*;

  // env: idle, frame active, frame done; lvl: osc, suppress
  typedef struct packed {
    logic [7:0] op;
    logic [2:0] env;
    logic [3:0] evt;
    logic [4:0] pls;
    logic [1:0] lvl;
    logic [15:0] mask;
  } rscu_row_t;

  logic clock = 1'h0;
  logic sys_rst = 1'h1;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
  logic rf_idle = 1'h1;
  logic rx_frame_active = 1'h0;
  logic rx_frame_done = 1'h0;
  logic osc_enable, rx_fifo_flush, demod_reset, tx_fifo_flush, irq;
  logic ack_tx_start, ack_frame_pending, ack_suppress, avs_waitrequest;
  logic [15:0] receive_enable_mask;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic [7:0] st;
  logic [4:0] seen = 5'h00;
  logic clr = 1'h0;
  int num_errors = 0;
  int checks_done = 0;
  rscu_row_t rows [14];

  always #12.5 clock = ~clock;

  // Pulses seen since the last clear
  always @(posedge clock) begin
    if (clr) seen <= 5'h00;
    else seen <= seen | {ack_tx_start & ack_frame_pending, ack_tx_start, tx_fifo_flush,
                         rx_fifo_flush & demod_reset, rx_fifo_flush};
  end

  rscu_host host (.clock(clock), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n));

  rscu_top uut (.clock(clock), .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
    .rf_idle(rf_idle), .rx_frame_active(rx_frame_active), .rx_frame_done(rx_frame_done),
    .osc_enable(osc_enable), .rx_fifo_flush(rx_fifo_flush), .demod_reset(demod_reset),
    .tx_fifo_flush(tx_fifo_flush), .ack_tx_start(ack_tx_start),
    .ack_frame_pending(ack_frame_pending), .ack_suppress(ack_suppress),
    .receive_enable_mask(receive_enable_mask), .irq(irq), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  // Avalon access: hold until waitrequest is sampled low
  task automatic av(input logic we, input logic [3:0] a, input logic [31:0] d);
    int k;
    avs_address <= a;
    avs_write <= we;
    avs_read <= ~we;
    avs_writedata <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'h0) break;
    end
    rd = avs_readdata;
    if (k == 20) begin
      num_errors++;
      results();
    end
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clock);
  endtask

  task automatic strobe(input logic [7:0] op);
    host.sel();
    host.xfer(op, st);
    host.desel();
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    rows = '{
      '{OP_OSC_OFF, 3'h4, 4'h0, 5'h00, 2'h0, 16'h0000},
      '{OP_OSC_OFF, 3'h0, 4'h1, 5'h00, 2'h0, 16'h0000},
      '{OP_OSC_OFF, 3'h2, 4'h3, 5'h00, 2'h0, 16'h0000},
      '{OP_RX_FLUSH, 3'h4, 4'h0, 5'h03, 2'h2, 16'h0000},
      '{OP_RX_FLUSH, 3'h2, 4'h2, 5'h03, 2'h2, 16'h0000},
      '{OP_TX_FLUSH, 3'h6, 4'h0, 5'h04, 2'h2, 16'h0000},
      '{OP_ACK_SEND, 3'h4, 4'h1, 5'h00, 2'h2, 16'h0000},
      '{OP_ACK_PEND, 3'h4, 4'h1, 5'h00, 2'h2, 16'h0000},
      '{OP_ACK_SUPP, 3'h4, 4'h1, 5'h00, 2'h2, 16'h0000},
      '{OP_MASK_SET, 3'h4, 4'h0, 5'h00, 2'h2, 16'h2000},
      '{OP_MASK_CLR, 3'h4, 4'h4, 5'h00, 2'h2, 16'h0000},
      '{OP_ACK_SEND, 3'h3, 4'h8, 5'h08, 2'h2, 16'h0000},
      '{OP_ACK_PEND, 3'h3, 4'h8, 5'h18, 2'h2, 16'h0000},
      '{OP_ACK_SUPP, 3'h3, 4'h0, 5'h00, 2'h3, 16'h0000}};
    repeat (8) @(posedge clock);
    sys_rst <= 1'h0;
    @(posedge clock);
    chk("reset outputs", 32'h00160000, {11'h0, osc_enable, irq, avs_waitrequest,
        spi_miso_oe_n, ack_suppress, receive_enable_mask});
    repeat (4) @(posedge clock);
    av(1'h0, ADR_CTRL, 32'h0);
    chk("ctrl", 32'h00000003, rd);
    host.sel();
    host.xfer(8'hFF, st);
    host.desel();
    chk("status", 32'h000000C0, {24'h0, st});
    $display("reset test done");
    for (int i = 0; i < 14; i++) begin
      rf_idle <= rows[i].env[2];
      rx_frame_active <= rows[i].env[1];
      clr <= 1'h1;
      @(posedge clock);
      clr <= 1'h0;
      strobe(rows[i].op);
      chk("osc_enable", {31'h0, rows[i].lvl[1]}, {31'h0, osc_enable});
      chk("ack_suppress", {31'h0, rows[i].lvl[0]}, {31'h0, ack_suppress});
      chk("mask", {16'h0, rows[i].mask}, {16'h0, receive_enable_mask});
      if (rows[i].env[0]) begin
        rx_frame_done <= 1'h1;
        @(posedge clock);
        rx_frame_done <= 1'h0;
      end
      repeat (4) @(posedge clock);
      rx_frame_active <= 1'h0;
      chk("pulses", {27'h0, rows[i].pls}, {27'h0, seen});
      av(1'h0, ADR_EVT, 32'h0);
      chk("events", {28'h0, rows[i].evt}, rd);
      av(1'h1, ADR_EVT, 32'h0000000F);
      av(1'h1, ADR_CTRL, 32'h00000001);
      $display("row %0d done", i);
    end
    rf_idle <= 1'h1;
    host.sel();
    host.xfer(OP_MASK_OR, st);
    chk("status", 32'h000000C0, {24'h0, st});
    host.xfer(8'h12, st);
    host.xfer(8'h34, st);
    host.desel();
    chk("mask", 32'h00001234, {16'h0, receive_enable_mask});
    av(1'h0, ADR_MASK, 32'h0);
    chk("mask reg", 32'h00001234, rd);
    strobe(OP_MASK_SET);
    chk("status", 32'h000000C1, {24'h0, st});
    chk("mask", 32'h00003234, {16'h0, receive_enable_mask});
    strobe(OP_MASK_CLR);
    chk("mask", 32'h00001234, {16'h0, receive_enable_mask});
    av(1'h0, ADR_EVT, 32'h0);
    chk("events", 32'h0, rd);
    $display("mask test done");
    strobe(OP_ACK_SEND);
    chk("irq", 32'h0, {31'h0, irq});
    av(1'h1, ADR_EVT_EN, 32'h00000001);
    repeat (2) @(posedge clock);
    chk("irq", 32'h1, {31'h0, irq});
    av(1'h1, ADR_EVT_EN, 32'h0);
    repeat (2) @(posedge clock);
    chk("irq", 32'h0, {31'h0, irq});
    av(1'h1, ADR_EVT_EN, 32'h00000001);
    av(1'h1, ADR_EVT, 32'h00000001);
    repeat (2) @(posedge clock);
    chk("irq", 32'h0, {31'h0, irq});
    av(1'h1, 4'h2, 32'hFFFFFFFF);
    av(1'h0, ADR_EVT_EN, 32'h0);
    chk("event enable", 32'h00000001, rd);
    av(1'h0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("interrupt test done");
    sys_rst <= 1'h1;
    repeat (8) @(posedge clock);
    sys_rst <= 1'h0;
    @(posedge clock);
    chk("reset outputs", 32'h00160000, {11'h0, osc_enable, irq, avs_waitrequest,
        spi_miso_oe_n, ack_suppress, receive_enable_mask});
    chk("reset readdata", 32'h0, avs_readdata);
    av(1'h0, ADR_EVT_EN, 32'h0);
    chk("event enable", 32'h0, rd);
    $display("mid-run reset test done");
    results();
  end
endmodule
`default_nettype wire
